/* design/ecr_pkg.sv */
package ecr_pkg;
    localparam int NUM_CH  = 12;
    localparam int NUM_GEN = 74;
    localparam int GEN_W   = 7;
    localparam int IDX_W   = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CHANNEL  = 8'h04;
    localparam logic [7:0] OFS_CHSTATE  = 8'h0c;
    localparam logic [7:0] OFS_IEN_CLR  = 8'h10;
    localparam logic [7:0] OFS_IEN_SET  = 8'h14;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h18;

    // Field positions
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_KEEP_BIT  = 4;
    localparam int CHN_IDX_LSB    = 0;
    localparam int CHN_SOFT_EVENT_TRIGGER_BIT  = 8;
    localparam int CHN_GEN_LSB    = 16;
    localparam int CHN_PATH_LSB   = 24;
    localparam int CHN_EDGE_LSB   = 26;

    // Reset values
    localparam logic             KEEP_RST = 1'b0;
    localparam logic [GEN_W-1:0] GEN_NONE = 7'h00;
    localparam logic [1:0]       PATH_RST = 2'h0;
    localparam logic [1:0]       EDGE_RST = 2'h0;

    // Path codes
    localparam logic [1:0] PATH_SYNC   = 2'h0;
    localparam logic [1:0] PATH_RESYNC = 2'h1;
    localparam logic [1:0] PATH_ASYNC  = 2'h2;

    // Edge codes
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Two 12-bit per-channel vectors into the split 32-bit layout
    function automatic logic [31:0] ecr_pack(input logic [11:0] lo,
                                             input logic [11:0] hi);
        return {4'h0, hi[11:8], 4'h0, lo[11:8], hi[7:0], lo[7:0]};
    endfunction

    function automatic logic [11:0] ecr_lo(input logic [31:0] w);
        return {w[19:16], w[7:0]};
    endfunction

    function automatic logic [11:0] ecr_hi(input logic [31:0] w);
        return {w[27:24], w[15:8]};
    endfunction
endpackage

/* design/ecr_chan_if.sv */
`timescale 1ns/1ns
interface ecr_chan_if;
    logic [1:0] path;
    logic [1:0] edge_select;
    logic       clock_keep_on;
    logic       level_raw;
    logic       level_resync;
    logic       soft_event_trigger;
    logic       users_prepared;
    logic       users_done;
    logic       event_out;
    logic       channel_pending;
    logic       detected;
    logic       overrun;
    logic       clk_req;

    modport engine (
        input  path, edge_select, clock_keep_on, level_raw, level_resync,
               soft_event_trigger, users_prepared, users_done,
        output event_out, channel_pending, detected, overrun, clk_req
    );
    modport router (
        output path, edge_select, clock_keep_on, level_raw, level_resync,
               soft_event_trigger, users_prepared, users_done,
        input  event_out, channel_pending, detected, overrun, clk_req
    );
endinterface

/* design/ecr_channel.sv */
`timescale 1ns/1ns
module ecr_channel
    import ecr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic soft_rst,
    ecr_chan_if.engine ch
);
    logic clocked_path;
    logic level;
    logic prev_level;
    logic rise;
    logic fall;
    logic hit;
    logic event_q;

    assign clocked_path = (ch.path == PATH_SYNC) ||
                          (ch.path == PATH_RESYNC);
    assign level = (ch.path == PATH_RESYNC) ? ch.level_resync
                                            : ch.level_raw;
    assign rise = level & ~prev_level;
    assign fall = ~level & prev_level;

    // RQ4: edge select decode
    always_comb begin
        hit = 1'b0;
        case (ch.edge_select)
            EDGE_RISE: hit = rise;
            EDGE_FALL: hit = fall;
            EDGE_BOTH: hit = rise | fall;
            default:   hit = 1'b0;
        endcase
        // RQ8: soft event injected
        hit = clocked_path & (hit | ch.soft_event_trigger);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= level;
        end
    end

    // RQ21: soft reset cancels events
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            event_q <= 1'b0;
        end else begin
            event_q <= hit;
        end
    end

    // RQ6: pending until handled
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            ch.channel_pending <= 1'b0;
        end else if (hit) begin
            ch.channel_pending <= 1'b1;
        // RQ25: cleared on acknowledge
        end else if (ch.users_done) begin
            ch.channel_pending <= 1'b0;
        end
    end

    // RQ20: async path needs no clock
    // RQ23: async passes level straight
    assign ch.event_out = (ch.path == PATH_ASYNC) ? ch.level_raw : event_q;

    // RQ16: detect on event
    assign ch.detected = hit;
    // RQ13: overrun on users busy
    // RQ14: overrun on still pending
    assign ch.overrun = hit & (~ch.users_prepared | ch.channel_pending);

    // RQ19: clock only while needed
    // RQ22: keep-on forces clock
    assign ch.clk_req = ch.clock_keep_on |
                        (clocked_path & (hit | event_q | ch.channel_pending));
endmodule

/* design/ecr_event_router.sv */
`timescale 1ns/1ns
// Behaviour
// RQ1: configure channel with full word write
// RQ2: byte write selects channel for readback
// RQ3: generator select resets to none
// RQ4: clocked paths detect rise, fall, both
// RQ5: pulse generators must not use both
// RQ6: pending while users still handling event
// RQ7: ready status when all users ready
// RQ8: soft event bit injects channel event
// RQ9: soft event needs clocked path, rise, keep-on
// RQ10: flags set; enable set/clear registers
// RQ11: interrupt while flag and enable set
// RQ12: all sources share one interrupt line
// RQ13: overrun when user not ready
// RQ14: overrun when previous event still pending
// RQ15: no overrun on asynchronous path
// RQ16: detect flag set on channel event
// RQ17: no detect flag on asynchronous path
// RQ18: interrupt output needs no clock
// RQ19: sleep clock request only while needed
// RQ20: asynchronous path works without clock
// RQ21: software reset clears all, cancels events
// RQ22: keep-on bit holds channel clocks running
// RQ23: asynchronous path passes level unchanged
// RQ24: user multiplexer configured before channel
// RQ25: pending clears when all users acknowledge
module ecr_event_router
    import ecr_pkg::*;
#(
    parameter int N_GEN = NUM_GEN
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [N_GEN-1:0]  gen_level,
    input  wire logic [NUM_CH-1:0] users_prepared,
    input  wire logic [NUM_CH-1:0] users_done,
    output logic      [NUM_CH-1:0] ch_event,
    output logic      [NUM_CH-1:0] channel_gen_clock,
    output logic                   irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [GEN_W-1:0]  generator_select [NUM_CH];
    logic [1:0]        path_cfg         [NUM_CH];
    logic [1:0]        edge_select      [NUM_CH];
    logic [IDX_W-1:0]  sel_idx;
    logic              clock_keep_on;
    logic              soft_rst;
    logic [NUM_CH-1:0] soft_event_trigger;
    logic [NUM_CH-1:0] overrun_flag;
    logic [NUM_CH-1:0] detect_flag;
    logic [NUM_CH-1:0] ovr_en;
    logic [NUM_CH-1:0] evd_en;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] det_hit;
    logic [NUM_CH-1:0] ovr_hit;
    logic [N_GEN-1:0]  gs1;
    logic [N_GEN-1:0]  gs2;
    logic [N_GEN-1:0]  gs3;
    logic [N_GEN-1:0]  gen_stable;
    logic              wr;
    logic              rd_setup;
    logic              mapped;
    logic [IDX_W-1:0]  wr_idx;
    logic              wr_idx_ok;
    logic              sel_ok;
    logic [31:0]       chan_word;
    logic [31:0]       next_prdata;

    ecr_chan_if chif [NUM_CH] ();

    // Generator number zero means nothing connected
    function automatic logic gen_pick(input logic [N_GEN-1:0] v,
                                      input logic [GEN_W-1:0] g);
        logic r;
        r = 1'b0;
        for (int i = 0; i < N_GEN; i++) begin
            if (32'(g) == i + 1) begin
                r = v[i];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Resync: level accepted once second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gs1 <= '0;
            gs2 <= '0;
            gs3 <= '0;
        end else begin
            gs1 <= gen_level;
            gs2 <= gs1;
            gs3 <= gs2;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gen_stable <= '0;
        end else begin
            for (int i = 0; i < N_GEN; i++) begin
                if (gs2[i] == gs3[i]) begin
                    gen_stable[i] <= gs3[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign wr       = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_CHANNEL) ||
                      (paddr == OFS_CHSTATE) || (paddr == OFS_IEN_CLR) ||
                      (paddr == OFS_IEN_SET) || (paddr == OFS_IRQ_FLAG);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign wr_idx   = pwdata[CHN_IDX_LSB +: IDX_W];
    assign wr_idx_ok = 32'(wr_idx) < NUM_CH;
    assign sel_ok   = 32'(sel_idx) < NUM_CH;

    // Soft reset pulse; it overrides every other field of the write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            soft_rst <= 1'b0;
        end else begin
            // RQ21: software reset pulse
            soft_rst <= wr && (paddr == OFS_CTRL) && pstrb[0] &&
                        pwdata[CTRL_SWRST_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            clock_keep_on <= KEEP_RST;
        end else if (wr && (paddr == OFS_CTRL) && pstrb[0] &&
                     !pwdata[CTRL_SWRST_BIT]) begin
            clock_keep_on <= pwdata[CTRL_KEEP_BIT];
        end
    end

    // RQ2: byte write selects readback channel
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            sel_idx <= '0;
        end else if (wr && (paddr == OFS_CHANNEL) && pstrb[0]) begin
            sel_idx <= wr_idx;
        end
    end

    // RQ1: only full word write configures
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                // RQ3: no generator after reset
                generator_select[i] <= GEN_NONE;
                path_cfg[i]         <= PATH_RST;
                edge_select[i]      <= EDGE_RST;
            end
        end else if (wr && (paddr == OFS_CHANNEL) && (pstrb == 4'hf) &&
                     wr_idx_ok) begin
            generator_select[wr_idx] <= pwdata[CHN_GEN_LSB +: GEN_W];
            path_cfg[wr_idx]         <= pwdata[CHN_PATH_LSB +: 2];
            edge_select[wr_idx]      <= pwdata[CHN_EDGE_LSB +: 2];
        end
    end

    // RQ8: one-cycle soft event
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            soft_event_trigger <= '0;
        end else begin
            soft_event_trigger <= '0;
            if (wr && (paddr == OFS_CHANNEL) && (pstrb == 4'hf) &&
                wr_idx_ok && pwdata[CHN_SOFT_EVENT_TRIGGER_BIT]) begin
                soft_event_trigger[wr_idx] <= 1'b1;
            end
        end
    end

    // RQ10: enable set and clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            ovr_en <= '0;
            evd_en <= '0;
        end else if (wr && (pstrb == 4'hf)) begin
            if (paddr == OFS_IEN_SET) begin
                ovr_en <= ovr_en | ecr_lo(pwdata);
                evd_en <= evd_en | ecr_hi(pwdata);
            end else if (paddr == OFS_IEN_CLR) begin
                ovr_en <= ovr_en & ~ecr_lo(pwdata);
                evd_en <= evd_en & ~ecr_hi(pwdata);
            end
        end
    end

    // RQ10: flags set by events; a set beats a same-cycle clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_rst) begin
            overrun_flag <= '0;
            detect_flag  <= '0;
        end else if (wr && (paddr == OFS_IRQ_FLAG) && (pstrb == 4'hf)) begin
            overrun_flag <= (overrun_flag & ~ecr_lo(pwdata)) | ovr_hit;
            detect_flag  <= (detect_flag & ~ecr_hi(pwdata)) | det_hit;
        end else begin
            overrun_flag <= overrun_flag | ovr_hit;
            detect_flag  <= detect_flag | det_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign chan_word = sel_ok ?
        {4'h0, edge_select[sel_idx], path_cfg[sel_idx], 1'b0,
         generator_select[sel_idx], 12'h000, sel_idx} :
        {28'h0000000, sel_idx};

    always_comb begin
        next_prdata = 32'h00000000;
        if (paddr == OFS_CTRL) begin
            next_prdata[CTRL_KEEP_BIT] = clock_keep_on;
        end else if (paddr == OFS_CHANNEL) begin
            next_prdata = chan_word;
        end else if (paddr == OFS_CHSTATE) begin
            // RQ7: ready status bits
            next_prdata = ecr_pack(users_prepared, pend);
        end else if ((paddr == OFS_IEN_CLR) || (paddr == OFS_IEN_SET)) begin
            next_prdata = ecr_pack(ovr_en, evd_en);
        end else if (paddr == OFS_IRQ_FLAG) begin
            next_prdata = ecr_pack(overrun_flag, detect_flag);
        end
    end

    // Read data latched in the setup cycle keeps the bus at zero wait
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= next_prdata;
        end
    end

    // RQ11: request while flag and enable
    // RQ12: one shared line
    // RQ18: gated from flops only, no clock needed to hold it
    assign irq = |((overrun_flag & ovr_en) | (detect_flag & evd_en));

    ////////////////////////////////////////////////////////////////////////
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign chif[c].path               = path_cfg[c];
        assign chif[c].edge_select        = edge_select[c];
        assign chif[c].clock_keep_on      = clock_keep_on;
        assign chif[c].level_raw          = gen_pick(gen_level,
                                                     generator_select[c]);
        assign chif[c].level_resync       = gen_pick(gen_stable,
                                                     generator_select[c]);
        assign chif[c].soft_event_trigger = soft_event_trigger[c];
        assign chif[c].users_prepared     = users_prepared[c];
        assign chif[c].users_done         = users_done[c];
        assign ch_event[c]                = chif[c].event_out;
        assign channel_gen_clock[c]       = chif[c].clk_req;
        assign pend[c]                    = chif[c].channel_pending;
        // RQ15: engine gates overrun off async path
        // RQ17: engine gates detect off async path
        assign ovr_hit[c]                 = chif[c].overrun;
        assign det_hit[c]                 = chif[c].detected;

        ecr_channel u_ch (
            .ref_clk  (ref_clk),
            .rst_n    (rst_n),
            .soft_rst (soft_rst),
            .ch       (chif[c])
        );
    end
endmodule

/* sim/ecr_event_router_props.sv */
`timescale 1ns/1ns
module ecr_event_router_props
    import ecr_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [NUM_CH-1:0] users_prepared,
    input wire logic [NUM_CH-1:0] ch_event,
    input wire logic              irq
);
    logic acc;
    logic wr;
    logic clr;
    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign clr = wr && (paddr == OFS_IRQ_FLAG || paddr == OFS_IEN_CLR
                        || paddr == OFS_CTRL);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_hole_error: assert property (acc && paddr == 8'h08 |->
        pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_ctrl_mapped: assert property (acc && paddr == OFS_CTRL |-> !pslverr)
        else $error("control access refused");
    // Must also hold while reset is low
    a_reset_quiet: assert property (disable iff (1'b0)
        !rst_n |=> !irq && ch_event == 12'h0)
        else $error("outputs active after reset");
    a_irq_cause: assert property ($rose(irq) |->
        (|ch_event) || $past(wr && paddr == OFS_IEN_SET))
        else $error("irq rose without event or enable");
    a_irq_drop: assert property ($fell(irq) |->
        $past(clr) || $past(clr, 2) || $past(clr, 3))
        else $error("irq fell without clear");
    a_swrst_quiet: assert property (wr && paddr == OFS_CTRL && pstrb[0]
        && pwdata[0] |-> ##3 !irq)
        else $error("irq survives soft reset");
    a_ready_echo: assert property (acc && !pwrite && paddr == OFS_CHSTATE
        |-> prdata[7:0] == $past(users_prepared[7:0]))
        else $error("ready status mismatch");
endmodule
bind ecr_event_router ecr_event_router_props u_props (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .users_prepared, .ch_event, .irq);

/* sim/ecr_user_model.sv */
`timescale 1ns/1ns
module ecr_user_model
    import ecr_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [3:0]        lag,
    input  wire logic [NUM_CH-1:0] hold_off,
    input  wire logic [NUM_CH-1:0] ch_event,
    output logic      [NUM_CH-1:0] users_prepared,
    output logic      [NUM_CH-1:0] users_done
);
    logic [3:0] cnt [NUM_CH];
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (!rst_n)
                cnt[i] <= 4'h0;
            else if (ch_event[i])
                cnt[i] <= lag;
            else if (cnt[i] != 4'h0)
                cnt[i] <= cnt[i] - 4'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            users_done[i] = cnt[i] == 4'h1;
            users_prepared[i] = !hold_off[i] && cnt[i] == 4'h0;
        end
    end
endmodule

/* sim/ecr_event_router_bench.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module ecr_event_router_bench
    import ecr_pkg::*;
;
    typedef struct packed {
        logic        w;
        logic [7:0]  a;
        logic [31:0] d;
        logic [3:0]  s;
        logic [31:0] e;
    } ecr_row_type;
    logic              ref_clk;
    logic              rst_n;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [7:0]        paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [NUM_GEN-1:0] gen_level;
    logic [NUM_CH-1:0] users_prepared;
    logic [NUM_CH-1:0] users_done;
    logic [NUM_CH-1:0] ch_event;
    logic [NUM_CH-1:0] channel_gen_clock;
    logic              irq;
    logic [3:0]        lag;
    logic [NUM_CH-1:0] hold_off;
    logic [31:0]       rd;
    int                fails;
    int                n_tests;
    int                cyc;
    int                ev1;
    int                ev2;
    ecr_row_type       rows [10] = '{
        '{1'b0, 8'h00, 32'h0, 4'h0, 32'h0},
        '{1'b0, 8'h04, 32'h0, 4'h0, 32'h0},
        '{1'b0, 8'h18, 32'h0, 4'h0, 32'h0},
        '{1'b1, 8'h14, 32'h101, 4'hf, 32'h101},
        '{1'b1, 8'h10, 32'h1, 4'hf, 32'h100},
        '{1'b1, 8'h04, 32'h0405_0003, 4'hf, 32'h0405_0003},
        '{1'b1, 8'h04, 32'h0, 4'h1, 32'h0},
        '{1'b1, 8'h04, 32'h3, 4'h1, 32'h0405_0003},
        '{1'b0, 8'h08, 32'h0, 4'h0, 32'h0},
        '{1'b1, 8'h00, 32'h10, 4'h1, 32'h10}};
    ecr_event_router DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .gen_level,
        .users_prepared, .users_done, .ch_event, .channel_gen_clock, .irq);
    ecr_user_model u_users (.ref_clk, .rst_n, .lag, .hold_off, .ch_event,
        .users_prepared, .users_done);
////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (ch_event[1]) ev1++;
        if (ch_event[2]) ev2++;
        // Whole run needs about 460 cycles
        if (cyc == 6000) begin
            fails++;
            wrap_up();
        end
    end
////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        `CHK(rd, e)
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic gen_to(input logic v, input int n);
        gen_level[0] <= v;
        wait_n(n);
    endtask
    function automatic logic [31:0] cfg(input logic [3:0] i,
        input logic [6:0] g, input logic [1:0] p, input logic [1:0] e);
        return {4'h0, e, p, 1'b0, g, 12'h0, i};
    endfunction
    task automatic wrap_up();
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {gen_level, hold_off, fails, n_tests, cyc, ev1, ev2} = '0;
        lag = 4'h2;
        wait_n(8);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            rdc(rows[i].a, rows[i].e);
        end
        @(negedge ref_clk);
        `CHK(channel_gen_clock[3], 1'b1)
        apb(1'b1, OFS_CTRL, 32'h0, 4'h1);
        // Both clocked path codes and each edge code; generator idle low
        for (int p = 0; p < 2; p++) begin
            for (int e = 0; e < 4; e++) begin
                apb(1'b1, OFS_CHANNEL,
                    cfg(4'h1, 7'h01, 2'(p), 2'(e)), 4'hf);
                apb(1'b1, OFS_IRQ_FLAG, 32'hffff_ffff, 4'hf);
                ev1 = 0;
                gen_to(1'b1, 12);
                gen_to(1'b0, 12);
                `CHK(ev1, (e == 3) ? 2 : (e == 0) ? 0 : 1)
                rdc(OFS_IRQ_FLAG, (e == 0) ? 32'h0 : 32'h200);
            end
        end
        apb(1'b1, OFS_CHANNEL, cfg(4'h1, 7'h01, PATH_ASYNC, EDGE_NONE), 4'hf);
        apb(1'b1, OFS_IRQ_FLAG, 32'hffff_ffff, 4'hf);
        gen_to(1'b1, 0);
        @(negedge ref_clk);
        `CHK(ch_event[1], 1'b1)
        @(posedge ref_clk);
        gen_to(1'b0, 0);
        @(negedge ref_clk);
        `CHK(ch_event[1], 1'b0)
        rdc(OFS_IRQ_FLAG, 32'h0);
        apb(1'b1, OFS_CHANNEL,
            cfg(4'h1, 7'h01, PATH_SYNC, EDGE_RISE), 4'hf);
        apb(1'b1, OFS_IEN_SET, 32'h2, 4'hf);
        hold_off <= 12'h002;
        gen_to(1'b1, 12);
        gen_to(1'b0, 12);
        rdc(OFS_IRQ_FLAG, 32'h202);
        `CHK(irq, 1'b1)
        apb(1'b1, OFS_IRQ_FLAG, 32'h2, 4'hf);
        hold_off <= 12'h0;
        lag <= 4'hc;
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        // Second rise lands while the first is pending
        gen_to(1'b1, 2);
        gen_to(1'b0, 2);
        gen_to(1'b1, 3);
        rdc(OFS_CHSTATE, 32'h000f_02fd);
        rdc(OFS_IRQ_FLAG, 32'h202);
        // Keep-on is off here, so only the pending event holds the clock
        `CHK(channel_gen_clock[1], 1'b1)
        gen_to(1'b0, 20);
        rdc(OFS_CHSTATE, 32'h000f_00ff);
        `CHK(channel_gen_clock[1], 1'b0)
        apb(1'b1, OFS_IEN_CLR, 32'h2, 4'hf);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        lag <= 4'h2;
        apb(1'b1, OFS_CTRL, 32'h10, 4'h1);
        apb(1'b1, OFS_IRQ_FLAG, 32'hffff_ffff, 4'hf);
        ev2 = 0;
        apb(1'b1, OFS_CHANNEL,
            cfg(4'h2, GEN_NONE, PATH_SYNC, EDGE_RISE) | 32'h100, 4'hf);
        wait_n(6);
        `CHK(ev2, 1)
        `CHK(channel_gen_clock[2], 1'b1)
        rdc(OFS_IRQ_FLAG, 32'h400);
        apb(1'b1, OFS_IEN_SET, 32'h0f0f_ffff, 4'hf);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        // Keep-on bit in the same write must be dropped
        apb(1'b1, OFS_CTRL, 32'h11, 4'h1);
        wait_n(3);
        rdc(OFS_IEN_SET, 32'h0);
        rdc(OFS_IRQ_FLAG, 32'h0);
        rdc(OFS_CTRL, 32'h0);
        rdc(OFS_CHANNEL, 32'h0);
        `CHK(channel_gen_clock, 12'h0)
        // Pin reset in mid-run must drop keep-on as well
        apb(1'b1, OFS_CTRL, 32'h10, 4'h1);
        rst_n <= 1'b0;
        wait_n(2);
        rst_n <= 1'b1;
        `CHK(channel_gen_clock, 12'h0)
        rdc(OFS_CTRL, 32'h0);
        wrap_up();
    end
endmodule
